// *** pkg/lcd_host_params.svh ***
// Operation
// R1: Instruction with bit 7 set loads pointer and selects text memory.
// R2: Single-line text addresses run from 00H to 4FH.
// R3: Two-line text addresses are 00H-27H and 40H-67H.
// R4: Status read returns busy on bit 7 and pointer below, parallel only.
// R5: Host waits for busy low before the next instruction.
// R6: Data write stores byte to selected memory, then steps the pointer.
// R7: Output data register is prefetched after address-set.
// R8: Cursor shift during text reads also prefetches the addressed byte.
// R9: Each data read steps the pointer by one in entry direction.
// R10: Read after write returns the older prefetched byte.
// R11: Display shift right after a glyph read may misbehave.
// R12: Host allows half an oscillator period after busy falls.
// R13: Four-bit mode uses pins 4-7, upper nibble first.
// R14: Four-bit busy rises only after the second nibble.
// R15: Eight-bit mode moves a byte in one strobe.
// R16: Two straps choose parallel, I2C or four-line SPI.
// R17: SPI uses chip select, serial data, clock on pins 5,7,6 plus select.
// R18: SPI clock idles high, data sampled on rising edges.
// R19: In I2C mode host ties chip select low and sets width bit.
// R20: I2C start is data falling, stop is data rising, clock high.
// R21: Data line holds stable while I2C clock is high.
// R22: Addressed slave pulls data low on the ninth clock of each byte.
// R23: I2C address is one of four, low bits from two straps.
// R24: Control byte carries continuation and select bits, then a data byte.
// R25: Select bit high writes memory, low executes instructions.
// R26: Width bit set means eight-bit, clear means four-bit transfers.
// R27: SPI bytes arrive MSB first; clocks ignored while chip select high.
// R28: All links feed one common write path.
`ifndef LCD_HOST_PARAMS_SVH
`define LCD_HOST_PARAMS_SVH
`define CLK_PERIOD_NS 10
`define TIME_INSTR_NS 18500
`define INSTR_CYCLES ((`TIME_INSTR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SINGLE_LAST 7'h4f
`define LINE1_LAST 7'h27
`define LINE2_FIRST 7'h40
`define LINE2_LAST 7'h67
`define I2C_BASE_ADDR 7'h3c
`define PIN_CSN 5
`define PIN_SPI_DATA 7
`define PIN_SDA 6
`define PIN_SCL 7
`define RESET_WIDE 1'b1
`define RESET_INC 1'b1
`endif

// *** pkg/lcd_host_pkg.sv ***
`default_nettype none
package lcd_host_pkg;
    typedef enum logic [1:0] {LINK_PARALLEL, LINK_I2C, LINK_SPI} link_sel_t;
    typedef enum logic [1:0] {I2C_IDLE, I2C_ADDR, I2C_CTRL, I2C_DATA} i2c_state_t;
    // One host access, whichever link carried it
    typedef struct packed {
        logic rs;
        logic [7:0] data;
    } host_access_t;
endpackage
`default_nettype wire

// *** rtl/spi_byte_rx.sv ***
`default_nettype none
module spi_byte_rx (
    // Link clock and clears
    input wire logic spi_sclk,
    input wire logic reset,
    // Link pins
    input wire logic chip_select_n,
    input wire logic serial_in_line,
    input wire logic register_select_line,
    // Byte handed to the core domain
    output var lcd_host_pkg::host_access_t byte_hold,
    output logic byte_toggle
);
    logic [2:0] bit_cnt_r;
    logic [6:0] shift_r;

    // Chip select high clears the count, so a cut frame leaves no stale bits
    always_ff @(posedge spi_sclk or posedge chip_select_n) begin
        if (chip_select_n) begin
            bit_cnt_r <= 3'h0; // R27
        end else begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
        end
    end

    // Rising edge sampling, MSB first
    always_ff @(posedge spi_sclk) begin
        if (!chip_select_n) begin
            shift_r <= {shift_r[5:0], serial_in_line}; // R18 R27
        end
    end

    // Word stays put for eight link clocks, far longer than the core sync
    always_ff @(posedge spi_sclk or posedge reset) begin
        if (reset) begin
            byte_toggle <= 1'b0;
            byte_hold <= '0;
        end else if (!chip_select_n && bit_cnt_r == 3'h7) begin
            byte_hold <= {register_select_line, shift_r, serial_in_line}; // R17
            byte_toggle <= ~byte_toggle;
        end
    end

    property p_spi_byte_done;
        @(posedge spi_sclk) disable iff (reset)
        (!chip_select_n && bit_cnt_r == 3'h7) |=> (byte_toggle != $past(byte_toggle));
    endproperty
    a_spi_byte_done: assert property (p_spi_byte_done) else $error("SPI byte not handed over"); // R27
endmodule
`default_nettype wire

// *** rtl/lcd_host_access_port.sv ***
`include "lcd_host_params.svh"
`default_nettype none
module lcd_host_access_port #(
    parameter int INSTR_CYCLES = `INSTR_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Straps
    input wire logic link_strap_high,
    input wire logic link_strap_low,
    input wire logic slave_addr_strap0,
    input wire logic slave_addr_strap1,
    // Parallel bus, pins shared with the serial links
    input wire logic bus_enable,
    input wire logic register_select_line,
    input wire logic read_not_write,
    input wire logic [7:0] parallel_data_in,
    output logic [7:0] parallel_data_out,
    output logic [7:0] parallel_data_oe,
    // SPI clock, carried on data pin 6
    input wire logic spi_sclk,
    // Memory port
    output logic mem_wr_en,
    output logic mem_rd_en,
    output logic mem_glyph_sel,
    output logic [6:0] mem_addr,
    output logic [7:0] mem_wr_data,
    input wire logic [7:0] mem_rd_data,
    // Instructions for the display logic
    output logic instr_valid,
    output logic [7:0] instr_code,
    // Status
    output logic busy_indicator,
    output logic [6:0] address_pointer,
    output logic bus_width_bit,
    output logic two_line_mode,
    output logic entry_increment
);
    localparam int BW = $clog2(INSTR_CYCLES + 1);

    // Next address with the line layout folded in
    function automatic logic [6:0] step_addr(input logic [6:0] a, input logic up,
                                             input logic two, input logic glyph);
        logic [6:0] r;
        r = up ? a + 7'h01 : a - 7'h01;
        if (glyph) begin
            r[6] = 1'b0;
        end else if (!two) begin
            if (up && a >= `SINGLE_LAST) begin
                r = 7'h00; // R2
            end else if (!up && (a == 7'h00 || a > `SINGLE_LAST)) begin
                r = `SINGLE_LAST; // R2
            end
        end else begin
            if (up && a == `LINE1_LAST) begin
                r = `LINE2_FIRST; // R3
            end else if (up && a >= `LINE2_LAST) begin
                r = 7'h00; // R3
            end else if (!up && a == 7'h00) begin
                r = `LINE2_LAST; // R3
            end else if (!up && a == `LINE2_FIRST) begin
                r = `LINE1_LAST; // R3
            end
        end
        return r;
    endfunction

    function automatic lcd_host_pkg::link_sel_t decode_link(input logic hi, input logic lo);
        if (hi && !lo) begin
            return lcd_host_pkg::LINK_SPI;
        end else if (!hi && lo) begin
            return lcd_host_pkg::LINK_I2C;
        end
        return lcd_host_pkg::LINK_PARALLEL;
    endfunction

    // Pin synchronisers
    logic [14:0] pin_s1_r;
    logic [14:0] pin_s2_r;
    always_ff @(posedge ref_clk) begin
        pin_s1_r <= {link_strap_high, link_strap_low, slave_addr_strap1, slave_addr_strap0,
                     bus_enable, register_select_line, read_not_write, parallel_data_in};
        pin_s2_r <= pin_s1_r;
    end

    logic [7:0] db_s;
    logic e_s;
    logic rs_s;
    logic rw_s;
    lcd_host_pkg::link_sel_t link;
    assign db_s = pin_s2_r[7:0];
    assign rw_s = pin_s2_r[8];
    assign rs_s = pin_s2_r[9];
    assign e_s = pin_s2_r[10];
    assign link = decode_link(pin_s2_r[14], pin_s2_r[13]); // R16

    // Core state
    logic [6:0] ptr_r;
    logic glyph_r;
    logic inc_r;
    logic wide_r;
    logic two_r;
    logic busy_r;
    logic [BW-1:0] busy_cnt_r;
    logic [7:0] out_data_r;
    logic rd_pend_r;
    logic e_prev_r;
    logic nib_r;
    logic [3:0] upper_r;

    assign address_pointer = ptr_r;
    assign busy_indicator = busy_r;
    assign mem_glyph_sel = glyph_r;
    assign entry_increment = inc_r;
    assign bus_width_bit = wide_r;
    assign two_line_mode = two_r;

    logic e_fall;
    logic par_read_done;
    assign e_fall = e_prev_r && !e_s && link == lcd_host_pkg::LINK_PARALLEL;
    assign par_read_done = e_fall && rw_s && rs_s && (wide_r || nib_r); // R9

    // Strobe edge tracking and nibble phase
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            e_prev_r <= 1'b0;
            nib_r <= 1'b0;
            upper_r <= 4'h0;
        end else begin
            e_prev_r <= e_s;
            if (e_fall && !wide_r) begin
                nib_r <= ~nib_r; // R13
                if (!nib_r) begin
                    upper_r <= db_s[7:4];
                end
            end else if (wide_r) begin
                nib_r <= 1'b0;
            end
        end
    end

    // SPI byte crossing by toggle
    lcd_host_pkg::host_access_t spi_byte;
    logic spi_tog;
    logic tog_s1_r;
    logic tog_s2_r;
    logic tog_prev_r;
    spi_byte_rx u_spi (
        .spi_sclk(spi_sclk),
        .reset(reset),
        .chip_select_n(parallel_data_in[`PIN_CSN]),
        .serial_in_line(parallel_data_in[`PIN_SPI_DATA]),
        .register_select_line(register_select_line),
        .byte_hold(spi_byte),
        .byte_toggle(spi_tog)
    );
    always_ff @(posedge ref_clk) begin
        tog_s1_r <= spi_tog;
        if (reset) begin
            tog_s2_r <= 1'b0;
            tog_prev_r <= 1'b0;
        end else begin
            tog_s2_r <= tog_s1_r;
            tog_prev_r <= tog_s2_r;
        end
    end

    // I2C slave, sampled through the pin synchronisers
    lcd_host_pkg::i2c_state_t i2c_st_r;
    logic scl_prev_r;
    logic sda_prev_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] i2c_sh_r;
    logic ack_r;
    logic sel_r;
    logic cont_r;
    logic scl;
    logic sda;
    logic i2c_on;
    logic scl_fall;
    logic byte_end;
    logic addr_hit;
    assign scl = db_s[`PIN_SCL];
    assign sda = db_s[`PIN_SDA];
    assign i2c_on = link == lcd_host_pkg::LINK_I2C;
    assign scl_fall = i2c_on && scl_prev_r && !scl;
    assign byte_end = scl_fall && bit_cnt_r == 4'h8 && !ack_r
                      && i2c_st_r != lcd_host_pkg::I2C_IDLE;
    assign addr_hit = i2c_sh_r == {`I2C_BASE_ADDR | {5'h00, pin_s2_r[12:11]}, 1'b0}; // R23

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            scl_prev_r <= 1'b1;
            sda_prev_r <= 1'b1;
            i2c_st_r <= lcd_host_pkg::I2C_IDLE;
            bit_cnt_r <= 4'h0;
            i2c_sh_r <= 8'h00;
            ack_r <= 1'b0;
            sel_r <= 1'b0;
        end else begin
            scl_prev_r <= scl;
            sda_prev_r <= sda;
            if (i2c_on && scl && scl_prev_r && sda_prev_r && !sda) begin
                i2c_st_r <= lcd_host_pkg::I2C_ADDR; // R20
                bit_cnt_r <= 4'h0;
                ack_r <= 1'b0;
            end else if (i2c_on && scl && scl_prev_r && !sda_prev_r && sda) begin
                i2c_st_r <= lcd_host_pkg::I2C_IDLE; // R20
                ack_r <= 1'b0;
            end else if (i2c_on && scl && !scl_prev_r && bit_cnt_r < 4'h8) begin
                i2c_sh_r <= {i2c_sh_r[6:0], sda}; // R21
                bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (byte_end) begin
                unique case (i2c_st_r)
                    lcd_host_pkg::I2C_ADDR: begin
                        ack_r <= addr_hit; // R22
                        i2c_st_r <= addr_hit ? lcd_host_pkg::I2C_CTRL : lcd_host_pkg::I2C_IDLE;
                    end
                    lcd_host_pkg::I2C_CTRL: begin
                        ack_r <= 1'b1; // R22
                        sel_r <= i2c_sh_r[6]; // R24
                        i2c_st_r <= lcd_host_pkg::I2C_DATA;
                    end
                    lcd_host_pkg::I2C_DATA: begin
                        ack_r <= 1'b1; // R22
                        // A set continuation flag means another control byte follows
                        if (cont_r) begin
                            i2c_st_r <= lcd_host_pkg::I2C_CTRL; // R24
                        end
                    end
                    lcd_host_pkg::I2C_IDLE: begin
                        ack_r <= 1'b0;
                    end
                endcase
            end else if (scl_fall && ack_r) begin
                ack_r <= 1'b0;
                bit_cnt_r <= 4'h0;
            end
        end
    end

    // Continuation flag of the last control byte decides what follows
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cont_r <= 1'b0;
        end else if (byte_end && i2c_st_r == lcd_host_pkg::I2C_CTRL) begin
            cont_r <= i2c_sh_r[7]; // R24
        end
    end
    logic i2c_data_byte;
    assign i2c_data_byte = byte_end && i2c_st_r == lcd_host_pkg::I2C_DATA;

    // Common write path from all three links
    logic acc_valid;
    lcd_host_pkg::host_access_t acc;
    always_comb begin
        acc_valid = 1'b0;
        acc = '0;
        unique case (link)
            lcd_host_pkg::LINK_PARALLEL: begin
                acc_valid = e_fall && !rw_s && (wide_r || nib_r); // R14 R15
                acc = {rs_s, wide_r ? db_s : {upper_r, db_s[7:4]}}; // R13 R15
            end
            lcd_host_pkg::LINK_SPI: begin
                acc_valid = tog_s2_r != tog_prev_r;
                acc = spi_byte;
            end
            lcd_host_pkg::LINK_I2C: begin
                acc_valid = i2c_data_byte;
                acc = {sel_r, i2c_sh_r}; // R25
            end
            default: begin
                acc_valid = 1'b0;
            end
        endcase
    end // R28

    // Pointer, memory select, modes and prefetch
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ptr_r <= 7'h00;
            glyph_r <= 1'b0;
            inc_r <= `RESET_INC;
            wide_r <= `RESET_WIDE;
            two_r <= 1'b0;
            mem_wr_en <= 1'b0;
            mem_rd_en <= 1'b0;
            mem_addr <= 7'h00;
            mem_wr_data <= 8'h00;
            instr_valid <= 1'b0;
            instr_code <= 8'h00;
        end else begin
            mem_wr_en <= 1'b0;
            mem_rd_en <= 1'b0;
            instr_valid <= 1'b0;
            if (acc_valid && acc.rs) begin
                mem_wr_en <= 1'b1; // R6
                mem_addr <= ptr_r;
                mem_wr_data <= acc.data;
                ptr_r <= step_addr(ptr_r, inc_r, two_r, glyph_r); // R6 R10
            end else if (acc_valid) begin
                instr_valid <= 1'b1;
                // Display shifts pass on untouched; after a glyph read their effect is not promised
                instr_code <= acc.data; // R11
                if (acc.data[7]) begin
                    ptr_r <= acc.data[6:0]; // R1
                    glyph_r <= 1'b0;
                    mem_addr <= acc.data[6:0];
                    mem_rd_en <= 1'b1; // R7
                end else if (acc.data[6]) begin
                    ptr_r <= {1'b0, acc.data[5:0]};
                    glyph_r <= 1'b1;
                    mem_addr <= {1'b0, acc.data[5:0]};
                    mem_rd_en <= 1'b1; // R7
                end else if (acc.data[5]) begin
                    wide_r <= acc.data[4]; // R26
                    two_r <= acc.data[3];
                end else if (acc.data[4] && !acc.data[3]) begin
                    ptr_r <= step_addr(ptr_r, acc.data[2], two_r, glyph_r);
                    mem_addr <= step_addr(ptr_r, acc.data[2], two_r, glyph_r);
                    mem_rd_en <= !glyph_r; // R8
                end else if (acc.data[7:2] == 6'h01) begin
                    inc_r <= acc.data[1];
                end else if (acc.data[7:1] == 7'h01) begin
                    ptr_r <= 7'h00;
                    glyph_r <= 1'b0;
                end else if (acc.data == 8'h01) begin
                    ptr_r <= 7'h00;
                    glyph_r <= 1'b0;
                    inc_r <= 1'b1;
                end
            end else if (par_read_done) begin
                ptr_r <= step_addr(ptr_r, inc_r, two_r, glyph_r); // R9
                mem_addr <= step_addr(ptr_r, inc_r, two_r, glyph_r);
                mem_rd_en <= 1'b1;
            end
        end
    end

    // Memory answers one cycle after the read strobe
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rd_pend_r <= 1'b0;
            out_data_r <= 8'h00;
        end else begin
            rd_pend_r <= mem_rd_en;
            if (rd_pend_r) begin
                out_data_r <= mem_rd_data; // R7 R10
            end
        end
    end

    // Busy covers the execution time of every accepted write
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            busy_r <= 1'b0;
            busy_cnt_r <= '0;
        end else if (acc_valid) begin
            busy_r <= 1'b1; // R14
            busy_cnt_r <= BW'(INSTR_CYCLES - 1);
        end else if (busy_cnt_r != '0) begin
            busy_cnt_r <= busy_cnt_r - 1'b1;
        end else begin
            busy_r <= 1'b0;
        end
    end

    // Pin drivers: parallel reads, I2C acknowledge
    logic [7:0] rd_word;
    assign rd_word = rs_s ? out_data_r : {busy_r, ptr_r}; // R4
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            parallel_data_out <= 8'h00;
            parallel_data_oe <= 8'h00;
        end else if (i2c_on) begin
            parallel_data_out <= 8'h00;
            parallel_data_oe <= {1'b0, ack_r, 6'h00}; // R22
        end else if (link == lcd_host_pkg::LINK_PARALLEL && e_s && rw_s) begin
            if (wide_r) begin
                parallel_data_out <= rd_word; // R15
                parallel_data_oe <= 8'hff;
            end else begin
                parallel_data_out <= {nib_r ? rd_word[3:0] : rd_word[7:4], 4'h0}; // R13
                parallel_data_oe <= 8'hf0;
            end
        end else begin
            parallel_data_out <= 8'h00;
            parallel_data_oe <= 8'h00;
        end
    end

    property p_busy_after_write;
        @(posedge ref_clk) disable iff (reset)
        acc_valid |=> busy_indicator [*8];
    endproperty
    a_busy_after_write: assert property (p_busy_after_write) else $error("Busy missing"); // R14

    property p_first_nibble_quiet;
        @(posedge ref_clk) disable iff (reset)
        (e_fall && !rw_s && !wide_r && !nib_r) |-> !acc_valid ##1 nib_r;
    endproperty
    a_first_nibble_quiet: assert property (p_first_nibble_quiet) else $error("Nibble early"); // R13

    property p_addr_set;
        @(posedge ref_clk) disable iff (reset)
        (acc_valid && !acc.rs && acc.data[7])
        |=> address_pointer == $past(acc.data[6:0]) && !mem_glyph_sel && mem_rd_en;
    endproperty
    a_addr_set: assert property (p_addr_set) else $error("Address set failed"); // R1

    property p_prefetch_capture;
        @(posedge ref_clk) disable iff (reset)
        mem_rd_en |=> ##1 out_data_r == $past(mem_rd_data);
    endproperty
    a_prefetch_capture: assert property (p_prefetch_capture) else $error("No prefetch"); // R7

    property p_data_write;
        @(posedge ref_clk) disable iff (reset)
        (acc_valid && acc.rs) |=> mem_wr_en && mem_wr_data == $past(acc.data)
            && mem_addr == $past(address_pointer) && !mem_rd_en;
    endproperty
    a_data_write: assert property (p_data_write) else $error("Data write wrong"); // R6

    property p_single_wrap;
        @(posedge ref_clk) disable iff (reset)
        (acc_valid && acc.rs && inc_r && !two_r && !glyph_r && ptr_r == `SINGLE_LAST)
        |=> address_pointer == 7'h00;
    endproperty
    a_single_wrap: assert property (p_single_wrap) else $error("Line wrap wrong"); // R2

    property p_line_jump;
        @(posedge ref_clk) disable iff (reset)
        (acc_valid && acc.rs && inc_r && two_r && !glyph_r && ptr_r == `LINE1_LAST)
        |=> address_pointer == `LINE2_FIRST;
    endproperty
    a_line_jump: assert property (p_line_jump) else $error("Second line jump wrong"); // R3

    property p_status_read;
        @(posedge ref_clk) disable iff (reset)
        (link == lcd_host_pkg::LINK_PARALLEL && e_s && rw_s && !rs_s && wide_r)
        |=> parallel_data_out == {$past(busy_r), $past(ptr_r)} && parallel_data_oe == 8'hff;
    endproperty
    a_status_read: assert property (p_status_read) else $error("Status read wrong"); // R4

    property p_read_step;
        @(posedge ref_clk) disable iff (reset)
        (par_read_done && !acc_valid) |=> ##1 rd_pend_r;
    endproperty
    a_read_step: assert property (p_read_step) else $error("Read did not refetch"); // R9

    property p_i2c_ack;
        @(posedge ref_clk) disable iff (reset)
        (byte_end && i2c_st_r == lcd_host_pkg::I2C_DATA) |=> ##1 parallel_data_oe[6]
            && !parallel_data_out[6];
    endproperty
    a_i2c_ack: assert property (p_i2c_ack) else $error("No I2C acknowledge"); // R22
endmodule
`default_nettype wire

// *** sim/disp_mem_model.sv ***
`default_nettype none
module disp_mem_model (
    // Memory port of the block
    input wire logic ref_clk,
    input wire logic mem_wr_en,
    input wire logic mem_rd_en,
    input wire logic mem_glyph_sel,
    input wire logic [6:0] mem_addr,
    input wire logic [7:0] mem_wr_data,
    output logic [7:0] mem_rd_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] store [256];
    // Cleared at start so that every prefetch returns a known byte
    initial begin
        foreach (store[i]) store[i] = 8'h00;
        mem_rd_data = 8'h00;
    end
    // Text and glyph bytes kept apart by the select bit; one cycle read latency
    always @(posedge ref_clk) begin
        if (mem_wr_en) store[{mem_glyph_sel, mem_addr}] <= mem_wr_data;
        if (mem_rd_en) mem_rd_data <= store[{mem_glyph_sel, mem_addr}];
    end
endmodule
`default_nettype wire

// *** sim/test_lcd_host_access_port.sv ***
`default_nettype none
module test_lcd_host_access_port;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 0, reset = 0, link_strap_high = 0, link_strap_low = 0;
    logic slave_addr_strap0 = 0, slave_addr_strap1 = 0, bus_enable = 0, spi_sclk = 1;
    logic register_select_line = 0, read_not_write = 0;
    logic [7:0] parallel_data_in = 0, parallel_data_out, parallel_data_oe;
    logic [7:0] mem_wr_data, mem_rd_data, instr_code, q, qo;
    logic mem_wr_en, mem_rd_en, mem_glyph_sel, instr_valid, busy_indicator;
    logic bus_width_bit, two_line_mode, entry_increment;
    logic [6:0] mem_addr, address_pointer;
    int miscompares = 0, samples_checked = 0;
    int wr_seen = 0, instr_seen = 0;
    // Strobes last one cycle, so they are counted rather than sampled
    always @(posedge ref_clk) begin
        wr_seen <= wr_seen + (mem_wr_en === 1'b1);
        instr_seen <= instr_seen + (instr_valid === 1'b1);
    end
    // Short busy time keeps the run brief
    lcd_host_access_port #(.INSTR_CYCLES(20)) lcd_host_access_port_inst (.*);
    disp_mem_model disp_mem_model_inst (.*);
    initial forever #5 ref_clk = ~ref_clk;
    task check(input string n, input logic [7:0] s, input logic [7:0] x);
        samples_checked++;
        if (s !== x) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, x, s);
        end
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task rst;
        reset <= 1;
        repeat (4) @(posedge ref_clk);
        reset <= 0;
        repeat (3) @(posedge ref_clk);
    endtask
    // One strobe; E held high and low long enough for the pin synchronisers
    task acc(input logic r, input logic w, input logic [7:0] d);
        @(posedge ref_clk);
        register_select_line <= r;
        read_not_write <= w;
        parallel_data_in <= d;
        @(posedge ref_clk) bus_enable <= 1;
        repeat (6) @(posedge ref_clk);
        q = parallel_data_out;
        qo = parallel_data_oe;
        bus_enable <= 0;
        repeat (6) @(posedge ref_clk);
    endtask
    // Host waits for busy to drop, then leaves a margin before the next strobe
    task idle;
        int i;
        for (i = 0; busy_indicator !== 1'b0 && i < 200; i++) @(posedge ref_clk);
        if (i == 200) begin
            miscompares++;
            report_and_stop;
        end
        repeat (2) @(posedge ref_clk);
    endtask
    // Offset of 3 ns keeps link edges clear of core clock edges
    task spi(input logic r, input logic [7:0] d);
        int i;
        @(posedge ref_clk);
        register_select_line <= r;
        parallel_data_in[5] <= 0;
        @(posedge ref_clk) #3;
        for (i = 7; i >= 0; i--) begin
            spi_sclk = 0;
            parallel_data_in[7] = d[i];
            #6 spi_sclk = 1;
            #6;
        end
        @(posedge ref_clk) parallel_data_in[5] <= 1;
        repeat (10) @(posedge ref_clk);
    endtask
    // Bit-banged master, each phase several core clocks long for the synchronisers
    task i2c(input logic [7:0] d);
        int i;
        for (i = 8; i >= 0; i--) begin
            @(posedge ref_clk) parallel_data_in[6] <= i ? d[i - 1] : 1'b1;
            repeat (4) @(posedge ref_clk);
            parallel_data_in[7] <= 1;
            repeat (4) @(posedge ref_clk);
            qo = parallel_data_oe;
            parallel_data_in[7] <= 0;
            repeat (3) @(posedge ref_clk);
        end
    endtask
    initial begin
        rst;
        check("width", bus_width_bit, 1);
        check("busy", busy_indicator, 0);
        acc(0, 0, 8'h85);
        check("busy", busy_indicator, 1);
        check("icode", instr_code, 8'h85);
        check("ptr", address_pointer, 7'h05);
        check("glyph", mem_glyph_sel, 0);
        idle;
        acc(1, 0, 8'ha5);
        check("wdata", mem_wr_data, 8'ha5);
        check("waddr", mem_addr, 7'h05);
        idle;
        acc(1, 0, 8'h5a);
        check("ptr", address_pointer, 7'h07);
        idle;
        acc(0, 1, 8'h00);
        check("status", q, 8'h07);
        check("oe", qo, 8'hff);
        $display("write test done");
        acc(0, 0, 8'h85);
        idle;
        acc(1, 1, 8'h00);
        check("rdata", q, 8'ha5);
        check("ptr", address_pointer, 7'h06);
        acc(1, 0, 8'h77);
        idle;
        acc(1, 1, 8'h00);
        check("rdata", q, 8'h5a);
        acc(0, 0, 8'h04);
        idle;
        check("inc", entry_increment, 0);
        acc(1, 1, 8'h00);
        check("ptr", address_pointer, 7'h07);
        $display("read test done");
        acc(0, 0, 8'h38);
        idle;
        check("two", two_line_mode, 1);
        acc(0, 0, 8'h28);
        idle;
        check("width", bus_width_bit, 0);
        acc(0, 0, 8'h80);
        check("busy", busy_indicator, 0);
        acc(0, 0, 8'ha0);
        check("busy", busy_indicator, 1);
        idle;
        check("ptr", address_pointer, 7'h0a);
        acc(0, 0, 8'h00);
        acc(0, 0, 8'h60);
        idle;
        acc(0, 0, 8'ha0);
        acc(0, 0, 8'h70);
        idle;
        acc(1, 0, 8'h10);
        acc(1, 0, 8'h20);
        idle;
        check("ptr", address_pointer, 7'h40);
        $display("nibble test done");
        link_strap_high <= 1;
        parallel_data_in <= 8'h20;
        rst;
        spi(0, 8'h93);
        check("ptr", address_pointer, 7'h13);
        idle;
        spi(1, 8'hc3);
        check("wdata", mem_wr_data, 8'hc3);
        check("ptr", address_pointer, 7'h14);
        idle;
        spi(0, 8'hcf);
        idle;
        spi(1, 8'h3c);
        check("ptr", address_pointer, 7'h00);
        $display("serial test done");
        link_strap_high <= 0;
        link_strap_low <= 1;
        parallel_data_in <= 8'hc0;
        rst;
        @(posedge ref_clk) parallel_data_in[6] <= 0;
        repeat (4) @(posedge ref_clk);
        parallel_data_in[7] <= 0;
        i2c(8'h78);
        check("ack", qo, 8'h40);
        i2c(8'h40);
        i2c(8'h5c);
        check("wdata", mem_wr_data, 8'h5c);
        check("ptr", address_pointer, 7'h01);
        $display("i2c test done");
        check("writes", 8'(wr_seen), 8'h07);
        check("instrs", 8'(instr_seen), 8'h0a);
        report_and_stop;
    end
    initial begin
        #400000;
        miscompares++;
        report_and_stop;
    end
endmodule
`default_nettype wire
